// ===== logic/hof_pkg.sv
// constants and types for the oscillator, calibration and fire pulse block
//
// Contract
// [RULE1] on-demand oscillator runs only during measurement
// [RULE2] start setting 0 off, 1 on, 2 480us
// [RULE3] settings 3,4,5-7 give 1.46/2.44/5.14 ms
// [RULE4] low-frequency reference always runs
// [RULE5] selector1 = 7 forwards reference to fire-input
// [RULE6] selector2 = 7 forwards reference/8 to start-enable
// [RULE7] calibration opcode measures, stores, raises interrupt
// [RULE8] calibration interval 2,4,8,16 reference periods
// [RULE9] result counts divided fast clock, 16.16
// [RULE10] host keeps start input enabled during calibration
// [RULE11] fire reference is doubled base clock divided
// [RULE12] host never programs fire divider zero
// [RULE13] pulse count zero disables, else exact count
// [RULE14] flight-time opcode begins a burst
// [RULE15] fire-as-start selects fire pulse as start
// [RULE16] idle level high impedance or ground
// [RULE17] phase bits per pulse, bit 15 zero
// [RULE18] phase shift disable bit 19 controls noise
// [RULE19] each pulse takes two reference periods
// [RULE20] two outputs, inverse option, individual disable
// [RULE21] after burst outputs return to idle
package hof_pkg;
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned REF_KHZ_X1000 = 32768;
  // settling delays in microseconds scaled by 100
  localparam int unsigned DLY0_US_X100 = 48000;
  localparam int unsigned DLY1_US_X100 = 146000;
  localparam int unsigned DLY2_US_X100 = 244000;
  localparam int unsigned DLY3_US_X100 = 514000;
  localparam int unsigned DLY0_CYC = DLY0_US_X100 * CLK_MHZ / 100;
  localparam int unsigned DLY1_CYC = DLY1_US_X100 * CLK_MHZ / 100;
  localparam int unsigned DLY2_CYC = DLY2_US_X100 * CLK_MHZ / 100;
  localparam int unsigned DLY3_CYC = DLY3_US_X100 * CLK_MHZ / 100;
  localparam logic [2:0] TEST_SEL_REF = 3'h7;
  localparam int unsigned REF_DIV_OUT = 8;
  localparam int unsigned PHASE_MAX_PULSES = 15;
  // register byte addresses
  localparam logic [7:0] ADDR_CFG0 = 8'h00;
  localparam logic [7:0] ADDR_CFG1 = 8'h04;
  localparam logic [7:0] ADDR_CMD = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0C;
  localparam logic [7:0] ADDR_RES = 8'h10;
  // cfg0 fields
  localparam int unsigned F_START = 0;
  localparam int unsigned F_CALP = 3;
  localparam int unsigned F_HSDIV = 5;
  localparam int unsigned F_FDIV = 8;
  localparam int unsigned F_FCNT = 12;
  localparam int unsigned F_TST1 = 20;
  localparam int unsigned F_TST2 = 23;
  // cfg1 fields
  localparam int unsigned F_PHASE = 0;
  localparam int unsigned F_FSTART = 16;
  localparam int unsigned F_IDLE = 17;
  localparam int unsigned F_PSDIS = 19;
  localparam int unsigned F_INV2 = 20;
  localparam int unsigned F_EN1 = 21;
  localparam int unsigned F_EN2 = 22;
  localparam logic [31:0] CFG0_RST = 32'h0000_0000;
  localparam logic [31:0] CFG1_RST = 32'h0060_0000;
  // command codes
  localparam logic [1:0] CMD_TOF = 2'h1;
  localparam logic [1:0] CMD_TEMP = 2'h2;
  localparam logic [1:0] CMD_CAL = 2'h3;

  typedef struct packed {
    logic [7:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } hof_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } hof_apb_rsp_t;

  typedef struct packed {
    logic up_o;
    logic up_oe;
    logic dn_o;
    logic dn_oe;
  } hof_fire_t;
endpackage : hof_pkg

// ===== logic/hof_fire_gen.sv
// fire pulse burst generator
`timescale 1ns/1ps
`default_nettype none
module hof_fire_gen
  import hof_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_base_tick,
  input wire logic i_go,
  input wire logic [3:0] i_fire_div,
  input wire logic [6:0] i_count,
  input wire logic [15:0] i_phase,
  input wire logic i_ps_dis,
  input wire logic i_noise,
  output logic o_level,
  output logic o_active,
  output logic o_first
);
  logic [4:0] div_q;
  logic ref_tick;
  logic [6:0] left_q;
  logic [3:0] idx_q;
  logic half_q;
  logic hold_q;

  // tick comes at twice the base rate, divided by div+1
  // [RULE11] doubled then divided
  always_ff @(posedge i_clock) begin
    if (i_rst || !o_active) begin
      div_q <= 5'h00;
    end else if (i_base_tick) begin
      div_q <= (div_q >= {1'b0, i_fire_div}) ? 5'h00 : div_q + 5'h01;
    end
  end
  assign ref_tick = i_base_tick && (div_q >= {1'b0, i_fire_div});

  // [RULE13] exact pulse count
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_active <= 1'b0;
      left_q <= 7'h00;
      idx_q <= 4'h0;
      half_q <= 1'b0;
      hold_q <= 1'b0;
      o_first <= 1'b0;
    end else if (!o_active) begin
      o_first <= 1'b0;
      // [RULE14] opcode starts burst
      if (i_go && i_count != 7'h00) begin
        o_active <= 1'b1;
        left_q <= i_count;
        idx_q <= 4'h0;
        half_q <= 1'b0;
        // [RULE18] noise shift delays first pulse
        hold_q <= !i_ps_dis && i_noise;
      end
    end else if (ref_tick) begin
      o_first <= !half_q && left_q == i_count && !hold_q;
      if (hold_q) begin
        hold_q <= 1'b0;
      // [RULE19] high and low phases
      end else if (!half_q) begin
        half_q <= 1'b1;
      end else begin
        half_q <= 1'b0;
        left_q <= left_q - 7'h01;
        idx_q <= idx_q + 4'h1;
        // [RULE21] back to idle
        if (left_q == 7'h01) begin
          o_active <= 1'b0;
        end
      end
    end else begin
      o_first <= 1'b0;
    end
  end

  // [RULE17] per-pulse phase, lsb first
  always_comb begin
    if (i_count <= 7'(PHASE_MAX_PULSES) && i_phase[idx_q]) begin
      o_level = o_active && !hold_q && half_q;
    end else begin
      o_level = o_active && !hold_q && !half_q;
    end
  end
endmodule : hof_fire_gen
`default_nettype wire

// ===== logic/hof_top.sv
// oscillator control, reference forwarding, calibration and fire outputs
//
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module hof_top
  import hof_pkg::*;
#(
  parameter int unsigned DLY0 = DLY0_CYC,
  parameter int unsigned DLY1 = DLY1_CYC,
  parameter int unsigned DLY2 = DLY2_CYC,
  parameter int unsigned DLY3 = DLY3_CYC
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire hof_apb_req_t i_apb,
  output hof_apb_rsp_t o_apb,
  input wire logic i_ref_clk,
  input wire logic i_hs_clk,
  input wire logic i_start_en,
  output logic o_hs_osc_en,
  output logic o_meas_start,
  output logic o_cal_irq,
  output logic o_fire_in_o,
  output logic o_fire_in_oe,
  output logic o_en_start_o,
  output logic o_en_start_oe,
  output hof_fire_t o_fire
);
  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_SETTLE = 4'b0010,
    S_MEAS = 4'b0100,
    S_CAL = 4'b1000
  } hof_state_t;

  hof_state_t state_q;
  logic [31:0] cfg0_q, cfg1_q, res_q;
  logic irq_q, tof_q;
  logic [1:0] cmd_d;
  logic cmd_v;
  logic [22:0] dly_q;
  logic ref_q, hs_q, ref_rise, hs_rise;
  logic [1:0] ref_div_q;
  logic ref8_q;
  logic [1:0] hsdiv_q;
  logic hs_tick;
  logic hs_fall, fire_tick;
  logic [31:0] rdata_d;
  logic [4:0] per_q;
  logic cal_run_q;
  logic [31:0] cnt_q;
  logic [15:0] lfsr_q;
  logic fire_level, fire_active, fire_first;
  logic go_q;
  logic wr, rd;
  logic [2:0] start_sel;
  logic [22:0] dly_sel;

  assign wr = i_apb.psel && i_apb.penable && i_apb.pwrite;
  assign rd = i_apb.psel && !i_apb.penable && !i_apb.pwrite;
  assign cmd_v = wr && i_apb.paddr == ADDR_CMD;
  assign cmd_d = i_apb.pwdata[1:0];
  assign start_sel = cfg0_q[F_START +: 3];

  // apb slave, one wait-free access
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      cfg0_q <= CFG0_RST;
      cfg1_q <= CFG1_RST;
      o_apb <= '0;
    end else begin
      o_apb.pready <= i_apb.psel && !i_apb.penable;
      o_apb.pslverr <= i_apb.psel && !i_apb.penable && !(i_apb.paddr inside
        {ADDR_CFG0, ADDR_CFG1, ADDR_CMD, ADDR_STAT, ADDR_RES});
      if (wr && i_apb.paddr == ADDR_CFG0) begin
        cfg0_q <= i_apb.pwdata;
      end
      if (wr && i_apb.paddr == ADDR_CFG1) begin
        cfg1_q <= i_apb.pwdata;
      end
      // unmapped offsets answer zero for either direction
      if (i_apb.psel && !i_apb.penable) begin
        o_apb.prdata <= rdata_d;
      end
    end
  end

  // read mux
  always_comb begin
    unique case (i_apb.paddr)
      ADDR_CFG0: rdata_d = cfg0_q;
      ADDR_CFG1: rdata_d = cfg1_q;
      ADDR_STAT: rdata_d = {27'h0, state_q[1], state_q[2], state_q[3], fire_active, irq_q};
      ADDR_RES: rdata_d = res_q;
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  // edges of the inputs taken as synchronous
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      ref_q <= 1'b0;
      hs_q <= 1'b0;
    end else begin
      ref_q <= i_ref_clk;
      hs_q <= i_hs_clk;
    end
  end
  assign ref_rise = i_ref_clk && !ref_q;
  assign hs_rise = i_hs_clk && !hs_q;
  assign hs_fall = !i_hs_clk && hs_q;

  // [RULE4] reference path has no enable
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      ref_div_q <= 2'h0;
      ref8_q <= 1'b0;
    end else if (ref_rise) begin
      ref_div_q <= ref_div_q + 2'h1;
      if (ref_div_q == 2'(REF_DIV_OUT / 2 - 1)) begin
        ref8_q <= !ref8_q;
      end
    end
  end

  // [RULE5] reference on fire-input pin
  // [RULE6] reference/8 on start-enable pin
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_fire_in_o <= 1'b0;
      o_fire_in_oe <= 1'b0;
      o_en_start_o <= 1'b0;
      o_en_start_oe <= 1'b0;
    end else begin
      o_fire_in_oe <= cfg0_q[F_TST1 +: 3] == TEST_SEL_REF;
      o_fire_in_o <= i_ref_clk;
      o_en_start_oe <= cfg0_q[F_TST2 +: 3] == TEST_SEL_REF;
      o_en_start_o <= ref8_q;
    end
  end

  // [RULE9] high-speed clock divided by 1, 2 or 4
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      hsdiv_q <= 2'h0;
    end else if (hs_rise) begin
      hsdiv_q <= hsdiv_q + 2'h1;
    end
  end
  always_comb begin
    unique case (cfg0_q[F_HSDIV +: 2])
      2'h0: hs_tick = hs_rise;
      2'h1: hs_tick = hs_rise && hsdiv_q[0];
      default: hs_tick = hs_rise && hsdiv_q == 2'h3;
    endcase
  end

  // [RULE11] both edges of divided clock double it
  always_comb begin
    unique case (cfg0_q[F_HSDIV +: 2])
      2'h0: fire_tick = hs_rise || hs_fall;
      2'h1: fire_tick = hs_rise;
      default: fire_tick = hs_rise && hsdiv_q[0];
    endcase
  end

  // [RULE2] [RULE3] settling delay by setting
  always_comb begin
    unique case (start_sel)
      3'h2: dly_sel = 23'(DLY0);
      3'h3: dly_sel = 23'(DLY1);
      3'h4: dly_sel = 23'(DLY2);
      default: dly_sel = 23'(DLY3);
    endcase
  end

  // sequencer
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state_q <= S_IDLE;
      dly_q <= 23'h0;
      tof_q <= 1'b0;
      go_q <= 1'b0;
      per_q <= 5'h00;
      cal_run_q <= 1'b0;
      cnt_q <= 32'h0;
      res_q <= 32'h0;
      irq_q <= 1'b0;
    end else begin
      go_q <= 1'b0;
      if (rd && i_apb.paddr == ADDR_RES) begin
        irq_q <= 1'b0;
      end
      unique case (state_q)
        S_IDLE: begin
          if (cmd_v && cmd_d != 2'h0) begin
            tof_q <= cmd_d == CMD_TOF;
            // [RULE7] calibration in every start setting
            if (cmd_d == CMD_CAL) begin
              state_q <= S_CAL;
              per_q <= 5'h00;
              cal_run_q <= 1'b0;
            // [RULE1] on-demand waits for settling
            end else if (start_sel > 3'h1) begin
              state_q <= S_SETTLE;
              dly_q <= dly_sel;
            end else begin
              state_q <= S_MEAS;
              go_q <= cmd_d == CMD_TOF;
            end
          end
        end
        S_SETTLE: begin
          if (dly_q <= 23'h1) begin
            state_q <= S_MEAS;
            go_q <= tof_q;
          end else begin
            dly_q <= dly_q - 23'h1;
          end
        end
        S_MEAS: begin
          if (!go_q && !fire_active) begin
            state_q <= S_IDLE;
          end
        end
        S_CAL: begin
          // [RULE7] [RULE8] count between reference edges
          if (ref_rise && i_start_en) begin
            if (!cal_run_q) begin
              cal_run_q <= 1'b1;
              cnt_q <= 32'h0;
              per_q <= 5'h00;
            end else if (per_q == 5'((2 << cfg0_q[F_CALP +: 2]) - 1)) begin
              res_q <= cnt_q;
              // [RULE7] set wins over read clear
              irq_q <= 1'b1;
              state_q <= S_IDLE;
            end else begin
              per_q <= per_q + 5'h01;
            end
          end
          // [RULE9] 16.16 fixed point, integer counts
          if (cal_run_q && hs_tick) begin
            cnt_q <= cnt_q + 32'h0001_0000;
          end
        end
      endcase
    end
  end

  // [RULE1] [RULE2] oscillator enable
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_hs_osc_en <= 1'b0;
    end else begin
      o_hs_osc_en <= start_sel == 3'h1 || (start_sel > 3'h1 && state_q != S_IDLE);
    end
  end

  // noise source for the phase shift
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      lfsr_q <= 16'hACE1;
    end else begin
      lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    end
  end

  hof_fire_gen i_hof_fire_gen (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_base_tick(fire_tick),
    .i_go(go_q),
    .i_fire_div(cfg0_q[F_FDIV +: 4]),
    .i_count(cfg0_q[F_FCNT +: 7]),
    .i_phase(cfg1_q[F_PHASE +: 16]),
    .i_ps_dis(cfg1_q[F_PSDIS]),
    .i_noise(lfsr_q[0]),
    .o_level(fire_level),
    .o_active(fire_active),
    .o_first(fire_first)
  );

  // [RULE15] fire pulse as start
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_meas_start <= 1'b0;
      o_cal_irq <= 1'b0;
    end else begin
      o_meas_start <= cfg1_q[F_FSTART] ? fire_first : go_q;
      o_cal_irq <= irq_q;
    end
  end

  // [RULE16] [RULE20] [RULE21] output drive
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_fire <= '0;
    end else begin
      o_fire.up_o <= fire_active && fire_level;
      o_fire.dn_o <= fire_active && (cfg1_q[F_INV2] ? !fire_level : fire_level);
      o_fire.up_oe <= cfg1_q[F_EN1] && (fire_active || cfg1_q[F_IDLE]);
      o_fire.dn_oe <= cfg1_q[F_EN2] && (fire_active || cfg1_q[F_IDLE]);
    end
  end
endmodule : hof_top
`default_nettype wire

// ===== tb/hof_chk.sv
// port checker for the oscillator, calibration and fire block
`timescale 1ns/1ps
`default_nettype none
module hof_chk
  import hof_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire hof_apb_req_t i_apb,
  input wire hof_apb_rsp_t o_apb,
  input wire logic i_ref_clk,
  input wire logic o_hs_osc_en,
  input wire logic o_meas_start,
  input wire logic o_cal_irq,
  input wire logic o_fire_in_o,
  input wire logic o_fire_in_oe,
  input wire logic o_en_start_oe,
  input wire hof_fire_t o_fire
);
  logic [31:0] c0_q, c1_q;
  logic [3:0] age_q;
  logic cal_q, acc, wr, ok;
  assign acc = i_apb.psel && i_apb.penable && o_apb.pready;
  assign wr = acc && i_apb.pwrite;
  assign ok = age_q == 4'hF;
  // shadow of the configuration, settled once age saturates
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      c0_q <= CFG0_RST;
      c1_q <= CFG1_RST;
      age_q <= 4'h0;
      cal_q <= 1'b0;
    end else begin
      if (wr && i_apb.paddr == ADDR_CFG0) c0_q <= i_apb.pwdata;
      if (wr && i_apb.paddr == ADDR_CFG1) c1_q <= i_apb.pwdata;
      if (wr && i_apb.paddr == ADDR_CMD && i_apb.pwdata[1:0] == CMD_CAL) cal_q <= 1'b1;
      age_q <= wr ? 4'h0 : age_q + {3'h0, !ok};
    end
  end
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_rst);
  sequence s_setup;
    i_apb.psel && !i_apb.penable;
  endsequence
  sequence s_res_read;
    acc && !i_apb.pwrite && i_apb.paddr == ADDR_RES;
  endsequence
  apb_ready_a: assert property (s_setup |=> o_apb.pready)
    else $error("pready missing after setup");
  ready_pulse_a: assert property (o_apb.pready |=> !o_apb.pready)
    else $error("pready held too long");
  unmapped_err_a: assert property (s_setup ##0 (i_apb.paddr > ADDR_RES)
    |=> o_apb.pslverr && o_apb.prdata == 32'h0) else $error("unmapped access accepted");
  osc_on_a: assert property (ok && c0_q[F_START+:3] == 3'h1 |-> o_hs_osc_en)
    else $error("oscillator not running");
  osc_off_a: assert property (ok && c0_q[F_START+:3] == 3'h0 |-> !o_hs_osc_en)
    else $error("oscillator not off");
  idle_gnd_a: assert property (ok && c0_q[F_FCNT+:7] == 7'h0 && c1_q[F_IDLE] && c1_q[F_EN1]
    |-> o_fire.up_oe && !o_fire.up_o) else $error("idle level not ground");
  idle_hiz_a: assert property (ok && c0_q[F_FCNT+:7] == 7'h0 && !c1_q[F_IDLE]
    |-> !o_fire.up_oe && !o_fire.dn_oe) else $error("idle level not floating");
  up_off_a: assert property (ok && !c1_q[F_EN1] |-> !o_fire.up_oe)
    else $error("disabled output driven");
  inv_pair_a: assert property (ok && c1_q[F_INV2] && o_fire.up_o |-> !o_fire.dn_o)
    else $error("second output not inverted");
  irq_cause_a: assert property ($rose(o_cal_irq) |-> cal_q)
    else $error("flag without calibration");
  irq_clear_a: assert property (s_res_read |-> ##[1:3] !o_cal_irq)
    else $error("flag not cleared by read");
  fwd_oe_a: assert property (ok && c0_q[F_TST1+:3] == TEST_SEL_REF |-> o_fire_in_oe)
    else $error("reference pin not driven");
  ref_follow_a: assert property (ok && c0_q[F_TST1+:3] == TEST_SEL_REF && $rose(i_ref_clk)
    |-> ##[1:4] o_fire_in_o) else $error("reference not forwarded");
  div_oe_a: assert property (ok && c0_q[F_TST2+:3] == TEST_SEL_REF |-> o_en_start_oe)
    else $error("divided reference pin not driven");
  start_pulse_a: assert property (o_meas_start |=> !o_meas_start)
    else $error("start longer than one cycle");
endmodule : hof_chk
bind hof_top hof_chk i_hof_chk (
  .i_clock(i_clock), .i_rst(i_rst), .i_apb(i_apb), .o_apb(o_apb), .i_ref_clk(i_ref_clk),
  .o_hs_osc_en(o_hs_osc_en), .o_meas_start(o_meas_start), .o_cal_irq(o_cal_irq),
  .o_fire_in_o(o_fire_in_o), .o_fire_in_oe(o_fire_in_oe), .o_en_start_oe(o_en_start_oe),
  .o_fire(o_fire)
);
`default_nettype wire

// ===== tb/hof_host.sv
// host model: apb master that issues opcodes and configuration
`timescale 1ns/1ps
`default_nettype none
module hof_host
  import hof_pkg::*;
(
  input wire logic i_clock,
  input wire hof_apb_rsp_t i_rsp,
  output hof_apb_req_t o_apb,
  output logic o_start_en
);
  initial begin
    o_apb = '0;
    o_start_en = 1'b1;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] rd, output logic err, output bit ok);
    if (w && a == ADDR_CFG0 && wd[F_FDIV+:4] == 4'h0) wd[F_FDIV] = 1'b1;
    if (w && a == ADDR_CFG1) wd[15] = 1'b0;
    ok = 1'b0;
    rd = 32'h0;
    err = 1'b0;
    @(posedge i_clock);
    o_apb <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: wd};
    @(posedge i_clock);
    o_apb.penable <= 1'b1;
    for (int i = 0; i < 64 && !ok; i++) begin
      @(posedge i_clock);
      if (i_rsp.pready === 1'b1) begin
        ok = 1'b1;
        rd = i_rsp.prdata;
        err = i_rsp.pslverr;
      end
    end
    // released lines must not keep their last value
    o_apb <= '{paddr: ~a, psel: 1'b0, penable: 1'b0, pwrite: ~w, pwdata: ~wd};
  endtask : xfer
endmodule : hof_host
`default_nettype wire

// ===== tb/hof_top_bench.sv
// self-checking bench for oscillator, calibration and fire pulses
`timescale 1ns/1ps
`default_nettype none
module hof_top_bench
  import hof_pkg::*;
;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic ref_q = 1'b0;
  logic hs_q = 1'b0;
  hof_apb_req_t apb;
  hof_apb_rsp_t rsp;
  hof_fire_t fire;
  logic start_en, osc_en, mstart, irq, fin_o, fin_oe, ens_o, ens_oe;
  logic up_p, ref_p, fin_p, ens_p, osc_p;
  int n_errors = 0, checks = 0, cyc = 0, rises = 0, hi = 0, nms = 0;
  int t_osc = 0, t_ms = 0, n_ref = 0, n_fin = 0, n_ens = 0;
  int dly[8] = '{0, 0, 20, 30, 40, 50, 50, 50};
  initial forever #2 clock = ~clock;
  always @(posedge clock) begin
    cyc <= cyc + 1;
    hs_q <= cyc[2];
    ref_q <= cyc[5];
  end
  always @(negedge clock) begin
    if (fire.up_o && !up_p) rises++;
    if (fire.up_o) hi++;
    if (mstart) nms++;
    if (mstart) t_ms = cyc;
    if (osc_en && !osc_p) t_osc = cyc;
    if (ref_q && !ref_p) n_ref++;
    if (fin_o && !fin_p) n_fin++;
    if (ens_o && !ens_p) n_ens++;
    {up_p, osc_p, ref_p, fin_p, ens_p} = {fire.up_o, osc_en, ref_q, fin_o, ens_o};
  end
  hof_top #(.DLY0(20), .DLY1(30), .DLY2(40), .DLY3(50)) i_hof_top (
    .i_clock(clock), .i_rst(rst), .i_apb(apb), .o_apb(rsp), .i_ref_clk(ref_q),
    .i_hs_clk(hs_q), .i_start_en(start_en), .o_hs_osc_en(osc_en), .o_meas_start(mstart),
    .o_cal_irq(irq), .o_fire_in_o(fin_o), .o_fire_in_oe(fin_oe), .o_en_start_o(ens_o),
    .o_en_start_oe(ens_oe), .o_fire(fire)
  );
  hof_host i_hof_host (.i_clock(clock), .i_rsp(rsp), .o_apb(apb), .o_start_en(start_en));
  task automatic conclude();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : conclude
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic near(input logic [31:0] got, input logic [31:0] exp, input int tol);
    checks++;
    if ($isunknown(got) || got > exp + tol || got + tol < exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : near
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] d, output logic e);
    bit ok;
    i_hof_host.xfer(w, a, wd, d, e, ok);
    if (!ok) begin
      n_errors++;
      conclude();
    end
  endtask : acc
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] d;
    logic e;
    acc(1'b1, a, wd, d, e);
  endtask : wr
  task automatic wait_idle();
    logic [31:0] d;
    logic e;
    for (int i = 0; i < 4000; i++) begin
      acc(1'b0, ADDR_STAT, 32'h0, d, e);
      if (d[4:1] === 4'h0) return;
    end
    n_errors++;
    conclude();
  endtask : wait_idle
  function automatic logic [31:0] cal_exp(int p, int dv);
    return ((2 << p) * 64) / (8 << dv);
  endfunction : cal_exp
  function automatic int rise_exp(logic [15:0] ph, int n);
    int r = 0;
    logic lv = 1'b0;
    for (int i = 0; i < n; i++) begin
      r += int'(ph[i] || !lv);
      lv = ph[i];
    end
    return r;
  endfunction : rise_exp
  initial begin
    logic [31:0] d, c1;
    logic e;
    int n, fd;
    logic [15:0] ph;
    void'($urandom(32'h7d60));
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    acc(1'b0, ADDR_CFG0, 32'h0, d, e);
    cmp(d, CFG0_RST);
    acc(1'b0, ADDR_CFG1, 32'h0, d, e);
    cmp(d, CFG1_RST);
    acc(1'b0, 8'h14, 32'h0, d, e);
    cmp({d[30:0], e}, 32'h1);
    repeat (20) @(posedge clock);
    wr(ADDR_CFG1, 32'h0022_0000);
    repeat (20) @(posedge clock);
    wr(ADDR_CFG1, 32'h0);
    repeat (20) @(posedge clock);
    wr(ADDR_CFG0, 32'h03F0_0001);
    {n_ref, n_fin, n_ens} = '0;
    repeat (2048) @(posedge clock);
    near(n_fin, n_ref, 1);
    near(n_ens, n_ref / 8, 1);
    cmp(osc_en, 1'b1);
    for (int p = 0; p < 4; p++) begin
      fd = $urandom_range(2);
      wr(ADDR_CFG0, 32'h1 | p << F_CALP | fd << F_HSDIV);
      wr(ADDR_CMD, CMD_CAL);
      wait_idle();
      repeat (2) @(posedge clock);
      cmp(irq, 1'b1);
      acc(1'b0, ADDR_RES, 32'h0, d, e);
      near(d[31:16], cal_exp(p, fd), 1);
      cmp(d[15:0], 16'h0);
      repeat (3) @(posedge clock);
      cmp(irq, 1'b0);
    end
    for (int k = 0; k < 10; k++) begin
      n = (k == 0) ? 0 : (k == 1) ? 15 : (k == 2) ? 1 : $urandom_range(15, 1);
      fd = (k == 1) ? 15 : (k == 2) ? 1 : $urandom_range(15, 1);
      ph = 16'($urandom()) & 16'h7FFF;
      c1 = ph | ($urandom() & 32'h001B_0000) | 32'h0060_0000;
      wr(ADDR_CFG0, 32'h1 | fd << F_FDIV | n << F_FCNT);
      wr(ADDR_CFG1, c1);
      {rises, hi, nms} = '0;
      wr(ADDR_CMD, CMD_TOF);
      wait_idle();
      cmp(rises, rise_exp(ph, n));
      near(hi, n * 4 * (fd + 1), 2 * n + 2);
      if (n > 0) cmp(nms, 1);
      cmp({fire.up_o, fire.up_oe}, {1'b0, c1[F_IDLE]});
    end
    for (int s = 2; s < 8; s++) begin
      wr(ADDR_CFG0, s | 32'h0000_1100);
      wr(ADDR_CFG1, 32'h0060_0000);
      wr(ADDR_CMD, CMD_TOF);
      wait_idle();
      near(t_ms - t_osc, dly[s], 4);
      repeat (8) @(posedge clock);
      cmp(osc_en, 1'b0);
    end
    wr(ADDR_CMD, CMD_TEMP);
    repeat (5) @(posedge clock);
    cmp(osc_en, 1'b1);
    wait_idle();
    conclude();
  end
endmodule : hof_top_bench
`default_nettype wire
